//--- icu_pkg.sv
// ==========================================================================
// Interrupt control unit shared definitions
package icu_pkg;

   // ========================================================================
   // Register map, byte addresses on the register bus
   localparam int unsigned ADDR_W        = 8;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_EN0       = 8'h04;
   localparam logic [7:0]  OFS_EN1       = 8'h08;
   localparam logic [7:0]  OFS_EN2       = 8'h0c;
   localparam logic [7:0]  OFS_FLG0      = 8'h10;
   localparam logic [7:0]  OFS_FLG1      = 8'h14;
   localparam logic [7:0]  OFS_FLG2      = 8'h18;
   localparam logic [7:0]  OFS_SHD_BASE  = 8'h40;
   localparam logic [7:0]  OFS_SHD_MASK  = 8'he3;
   localparam int unsigned SHD_NUM       = 8;

   // ========================================================================
   // Field positions
   localparam int unsigned CTRL_GLOBAL_BIT = 7;
   localparam int unsigned CTRL_GROUP_BIT  = 6;
   localparam int unsigned CTRL_EDGE_BIT   = 0;
   localparam int unsigned EN0_TIMER0_BIT  = 5;
   localparam int unsigned EN0_PINCHG_BIT  = 4;
   localparam int unsigned EN0_EXTPIN_BIT  = 0;
   localparam int unsigned EN1_OSCFAIL_BIT = 7;
   localparam int unsigned EN1_CLKSW_BIT   = 6;
   localparam int unsigned EN1_CONV_BIT    = 0;
   localparam int unsigned EN2_ZCROSS_BIT  = 6;
   localparam int unsigned EN2_CMP2_BIT    = 1;
   localparam int unsigned EN2_CMP1_BIT    = 0;
   localparam int unsigned STATUS_TIMEOUT_BIT   = 4;
   localparam int unsigned STATUS_POWERDOWN_BIT = 3;

   // ========================================================================
   // Implemented bits and reset values
   localparam logic [7:0]  CTRL_MASK  = 8'hc1;
   localparam logic [7:0]  CTRL_RST   = 8'h01;
   localparam logic [7:0]  EN0_MASK   = 8'h31;
   localparam logic [7:0]  EN1_MASK   = 8'hc1;
   localparam logic [7:0]  EN2_MASK   = 8'h43;
   localparam logic [7:0]  EN_RST     = 8'h00;
   localparam logic [7:0]  STATUS_SAVE_MASK = 8'he7;
   localparam logic [14:0] VECTOR_ADDR = 15'h0004;

   // ========================================================================
   // Shadow slots
   localparam int unsigned SHD_WORK   = 0;
   localparam int unsigned SHD_STATUS = 1;
   localparam int unsigned SHD_BANK   = 2;
   localparam int unsigned SHD_FSR0L  = 3;
   localparam int unsigned SHD_FSR0H  = 4;
   localparam int unsigned SHD_FSR1L  = 5;
   localparam int unsigned SHD_FSR1H  = 6;
   localparam int unsigned SHD_PCHI   = 7;

   // ========================================================================
   // Types
   typedef logic [SHD_NUM-1:0][7:0] icu_ctx_t;

   typedef struct packed {
      logic timer0_overflow;
      logic pin_change;
      logic osc_fail;
      logic clock_switch_done;
      logic converter_done;
      logic zero_cross;
      logic comparator_two;
      logic comparator_one;
   } icu_evt_t;

   typedef enum logic [0:0] {
      ICU_RUN,
      ICU_WAKE_SKIP
   } icu_mode_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  en0;
      logic [7:0]  en1;
      logic [7:0]  en2;
      logic [7:0]  flg0;
      logic [7:0]  flg1;
      logic [7:0]  flg2;
      icu_ctx_t    shadow;
      icu_mode_t   mode;
      logic        ext_prev;
      logic        ext_armed;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        entry;
      logic [14:0] vec_addr;
      logic        restore;
      icu_ctx_t    restore_ctx;
      logic        wake;
      logic        pending;
   } icu_state_t;

endpackage

//--- icu_top.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module icu_top #(
   parameter logic [7:0] WAKE_MASK0 = 8'h31,
   parameter logic [7:0] WAKE_MASK1 = 8'hc1,
   parameter logic [7:0] WAKE_MASK2 = 8'h43
) (
   // Clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst_b,
   // APB slave
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [icu_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   output logic [31:0]                    o_prdata,
   // Event sources and external pin
   input  wire icu_pkg::icu_evt_t         i_evt,
   input  wire logic                      i_ext_pin,
   // Core sequencer
   input  wire logic                      i_q1,
   input  wire logic                      i_sleeping,
   input  wire logic                      i_return_from_irq_instr,
   input  wire icu_pkg::icu_ctx_t         i_ctx,
   output logic                           o_entry,
   output logic [14:0]                    o_vec_addr,
   output logic                           o_restore,
   output icu_pkg::icu_ctx_t              o_restore_ctx,
   output logic                           o_wake,
   output logic                           o_irq_pending
);

   // =======================================================================
   // State
   icu_pkg::icu_state_t cur_ff;
   icu_pkg::icu_state_t nxt_ff;

   logic       acc;
   logic       hit;
   logic       wr_commit;
   logic [7:0] rd_byte;
   logic       ext_edge;
   logic       global_en;
   logic       group_en;
   logic       pending;
   logic       wake_req;
   logic       edge_rise;
   logic [7:0] term0;
   logic [7:0] term1;
   logic [7:0] term2;
   logic [7:0] set0;
   logic [7:0] set1;
   logic [7:0] set2;
   logic [2:0] shd_idx;
   logic       shd_hit;

   assign global_en = cur_ff.ctrl[icu_pkg::CTRL_GLOBAL_BIT];
   assign group_en  = cur_ff.ctrl[icu_pkg::CTRL_GROUP_BIT];
   assign edge_rise = cur_ff.ctrl[icu_pkg::CTRL_EDGE_BIT];

   // =======================================================================
   // Address decode
   assign shd_idx = i_paddr[4:2];
   assign shd_hit = ((i_paddr & icu_pkg::OFS_SHD_MASK) == icu_pkg::OFS_SHD_BASE);

   always_comb begin
      hit     = 1'b1;
      rd_byte = 8'h00;
      unique case (i_paddr)
         icu_pkg::OFS_CTRL: rd_byte = cur_ff.ctrl & icu_pkg::CTRL_MASK;
         icu_pkg::OFS_EN0:  rd_byte = cur_ff.en0 & icu_pkg::EN0_MASK;
         icu_pkg::OFS_EN1:  rd_byte = cur_ff.en1 & icu_pkg::EN1_MASK;
         icu_pkg::OFS_EN2:  rd_byte = cur_ff.en2 & icu_pkg::EN2_MASK;
         icu_pkg::OFS_FLG0: rd_byte = cur_ff.flg0;
         icu_pkg::OFS_FLG1: rd_byte = cur_ff.flg1;
         icu_pkg::OFS_FLG2: rd_byte = cur_ff.flg2;
         default: begin
            if (shd_hit) begin
               rd_byte = cur_ff.shadow[shd_idx];
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end

   // =======================================================================
   // Requests
   // Edge detect waits one cycle after reset so a pin already high is not taken as an edge
   assign ext_edge = cur_ff.ext_armed &
                     (edge_rise ? (i_ext_pin & ~cur_ff.ext_prev)
                                : (~i_ext_pin & cur_ff.ext_prev));

   assign set0 = {2'b00, i_evt.timer0_overflow, i_evt.pin_change, 3'b000, ext_edge};
   assign set1 = {i_evt.osc_fail, i_evt.clock_switch_done, 5'b00000, i_evt.converter_done};
   assign set2 = {1'b0, i_evt.zero_cross, 4'b0000, i_evt.comparator_two, i_evt.comparator_one};

   assign term0 = cur_ff.flg0 & cur_ff.en0;
   assign term1 = cur_ff.flg1 & cur_ff.en1;
   assign term2 = cur_ff.flg2 & cur_ff.en2;

   // Register 0 terms bypass the group gate
   assign pending = (|term0) | (group_en & ((|term1) | (|term2)));
   // Wake ignores the global enable; only clockless sources count
   assign wake_req = (|(term0 & WAKE_MASK0)) |
                     (group_en & ((|(term1 & WAKE_MASK1)) | (|(term2 & WAKE_MASK2))));

   assign acc       = i_psel & i_penable;
   assign wr_commit = acc & cur_ff.pready & i_pwrite & ~cur_ff.pslverr;

   // =======================================================================
   // Next state
   always_comb begin
      nxt_ff         = cur_ff;
      nxt_ff.pready  = 1'b0;
      nxt_ff.pslverr = 1'b0;
      nxt_ff.entry   = 1'b0;
      nxt_ff.restore = 1'b0;
      nxt_ff.wake    = 1'b0;
      nxt_ff.pending = pending;
      nxt_ff.vec_addr = icu_pkg::VECTOR_ADDR;

      // One wait state lets read data come from a flip-flop
      if (acc & ~cur_ff.pready) begin
         nxt_ff.pready  = 1'b1;
         nxt_ff.pslverr = ~hit;
         nxt_ff.prdata  = {24'h000000, rd_byte};
      end

      if (wr_commit) begin
         unique case (i_paddr)
            icu_pkg::OFS_CTRL: nxt_ff.ctrl = i_pwdata[7:0] & icu_pkg::CTRL_MASK;
            icu_pkg::OFS_EN0:  nxt_ff.en0  = i_pwdata[7:0] & icu_pkg::EN0_MASK;
            icu_pkg::OFS_EN1:  nxt_ff.en1  = i_pwdata[7:0] & icu_pkg::EN1_MASK;
            icu_pkg::OFS_EN2:  nxt_ff.en2  = i_pwdata[7:0] & icu_pkg::EN2_MASK;
            icu_pkg::OFS_FLG0: nxt_ff.flg0 = i_pwdata[7:0] & icu_pkg::EN0_MASK;
            icu_pkg::OFS_FLG1: nxt_ff.flg1 = i_pwdata[7:0] & icu_pkg::EN1_MASK;
            icu_pkg::OFS_FLG2: nxt_ff.flg2 = i_pwdata[7:0] & icu_pkg::EN2_MASK;
            default: begin
               if (shd_hit) begin
                  nxt_ff.shadow[shd_idx] = i_pwdata[7:0];
               end
            end
         endcase
      end

      // Hardware set beats a software clear in the same cycle
      nxt_ff.flg0 = nxt_ff.flg0 | set0;
      nxt_ff.flg1 = nxt_ff.flg1 | set1;
      nxt_ff.flg2 = nxt_ff.flg2 | set2;

      nxt_ff.ext_prev  = i_ext_pin;
      nxt_ff.ext_armed = 1'b1;

      // Return from service routine
      if (i_return_from_irq_instr) begin
         nxt_ff.restore     = 1'b1;
         nxt_ff.restore_ctx = cur_ff.shadow;
         nxt_ff.ctrl[icu_pkg::CTRL_GLOBAL_BIT] = 1'b1;
      end

      unique case (cur_ff.mode)
         icu_pkg::ICU_RUN: begin
            if (i_sleeping) begin
               if (wake_req) begin
                  nxt_ff.wake = 1'b1;
                  nxt_ff.mode = icu_pkg::ICU_WAKE_SKIP;
               end
            end else if (i_q1 & global_en & pending) begin
               nxt_ff.entry = 1'b1;
               nxt_ff.ctrl[icu_pkg::CTRL_GLOBAL_BIT] = 1'b0;
               nxt_ff.shadow = i_ctx;
               nxt_ff.shadow[icu_pkg::SHD_STATUS] =
                  i_ctx[icu_pkg::SHD_STATUS] & icu_pkg::STATUS_SAVE_MASK;
            end
         end
         icu_pkg::ICU_WAKE_SKIP: begin
            // This Q1 belongs to the instruction after sleep; vectoring waits for the next Q1
            if (i_q1 & ~i_sleeping) begin
               nxt_ff.mode = icu_pkg::ICU_RUN;
            end
         end
      endcase
   end

   // =======================================================================
   // Registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         cur_ff             <= '0;
         cur_ff.ctrl        <= icu_pkg::CTRL_RST;
         cur_ff.en0         <= icu_pkg::EN_RST;
         cur_ff.en1         <= icu_pkg::EN_RST;
         cur_ff.en2         <= icu_pkg::EN_RST;
         cur_ff.mode        <= icu_pkg::ICU_RUN;
         cur_ff.vec_addr    <= icu_pkg::VECTOR_ADDR;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // =======================================================================
   // Outputs
   assign o_pready      = cur_ff.pready;
   assign o_pslverr     = cur_ff.pslverr;
   assign o_prdata      = cur_ff.prdata;
   assign o_entry       = cur_ff.entry;
   assign o_vec_addr    = cur_ff.vec_addr;
   assign o_restore     = cur_ff.restore;
   assign o_restore_ctx = cur_ff.restore_ctx;
   assign o_wake        = cur_ff.wake;
   assign o_irq_pending = cur_ff.pending;

   // =======================================================================
   // Assertions
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);

   AST_RESET_DISABLED: assert property (@(posedge i_clk_sys) disable iff (1'b0)
      !i_rst_b |=> (cur_ff.ctrl == icu_pkg::CTRL_RST) && (cur_ff.en0 == 8'h00) &&
                   (cur_ff.en1 == 8'h00) && (cur_ff.en2 == 8'h00))
      else $error("Enables not cleared by reset");

   AST_ENTRY_CAUSE: assert property (
      o_entry |-> $past(global_en) && $past(pending) && $past(i_q1) && !$past(i_sleeping))
      else $error("Vector taken without enabled request");

   AST_FLAG_SETS: assert property (
      i_evt.converter_done |=> cur_ff.flg1[icu_pkg::EN1_CONV_BIT])
      else $error("Converter flag not set by event");

   AST_ENTRY_EFFECTS: assert property (
      o_entry |-> !global_en && (o_vec_addr == 15'h0004) && !$past(o_entry))
      else $error("Entry did not clear global enable or vector");

   AST_NO_ENTRY_DISABLED: assert property (
      !global_en |=> !o_entry)
      else $error("Vector taken with global enable clear");

   AST_RETURN: assert property (
      i_return_from_irq_instr |=> o_restore && global_en && (o_restore_ctx == $past(cur_ff.shadow)))
      else $error("Return did not restore and re-enable");

   AST_Q1_SAMPLE: assert property (
      (global_en && pending && !i_q1) |=> !o_entry)
      else $error("Request sampled outside Q1");

   AST_WAKE_SKIP: assert property (
      o_wake |=> (cur_ff.mode == icu_pkg::ICU_WAKE_SKIP) && !o_entry)
      else $error("Vector not deferred after wake");

   AST_EXT_EDGE: assert property (
      (cur_ff.ext_armed && edge_rise && !cur_ff.ext_prev && i_ext_pin) |=>
         cur_ff.flg0[icu_pkg::EN0_EXTPIN_BIT])
      else $error("Rising edge did not set pin flag");

   AST_SHADOW_STATUS: assert property (
      o_entry |-> (cur_ff.shadow[icu_pkg::SHD_STATUS] & ~icu_pkg::STATUS_SAVE_MASK) == 8'h00)
      else $error("Timeout or power-down saved into shadow");

   AST_GROUP_BYPASS: assert property (
      (o_entry && !$past(group_en)) |-> $past(|term0))
      else $error("Group-gated source vectored without group enable");

   AST_UNIMPL_ZERO: assert property (
      ((cur_ff.ctrl & ~icu_pkg::CTRL_MASK) == 8'h00) && ((cur_ff.en0 & ~icu_pkg::EN0_MASK) == 8'h00) &&
      ((cur_ff.en1 & ~icu_pkg::EN1_MASK) == 8'h00) && ((cur_ff.en2 & ~icu_pkg::EN2_MASK) == 8'h00))
      else $error("Unimplemented bit holds a one");

   AST_FLAG_STICKY: assert property (
      (cur_ff.flg2[icu_pkg::EN2_CMP1_BIT] && !wr_commit) |=> cur_ff.flg2[icu_pkg::EN2_CMP1_BIT])
      else $error("Flag dropped without software clear");

   // =======================================================================
   // Register and request checks
   // Possible entry cycles are left out of the control and shadow checks, return cycles of the control check only: entry writes both, return writes control
   AST_CTRL_WRITE: assert property (
      (wr_commit && (i_paddr == icu_pkg::OFS_CTRL) && !i_return_from_irq_instr && !(i_q1 && global_en)) |=>
         (cur_ff.ctrl == ($past(i_pwdata[7:0]) & icu_pkg::CTRL_MASK)))
      else $error("Control write did not land on its fields");

   AST_EN0_WRITE: assert property (
      (wr_commit && (i_paddr == icu_pkg::OFS_EN0)) |=> (cur_ff.en0 == ($past(i_pwdata[7:0]) & icu_pkg::EN0_MASK)))
      else $error("Enable register 0 write did not land");

   AST_EN1_WRITE: assert property (
      (wr_commit && (i_paddr == icu_pkg::OFS_EN1)) |=> (cur_ff.en1 == ($past(i_pwdata[7:0]) & icu_pkg::EN1_MASK)))
      else $error("Enable register 1 write did not land");

   AST_EN2_WRITE: assert property (
      (wr_commit && (i_paddr == icu_pkg::OFS_EN2)) |=> (cur_ff.en2 == ($past(i_pwdata[7:0]) & icu_pkg::EN2_MASK)))
      else $error("Enable register 2 write did not land");

   AST_SHADOW_WRITE: assert property (
      (wr_commit && shd_hit && !(i_q1 && global_en)) |=>
         (cur_ff.shadow[$past(shd_idx)] == $past(i_pwdata[7:0])))
      else $error("Shadow write did not land");

   AST_SHADOW_READ: assert property (
      (acc && !o_pready && !i_pwrite && shd_hit) |=> (o_prdata[7:0] == $past(cur_ff.shadow[shd_idx])))
      else $error("Shadow read returned another value");

   AST_WAKE_CAUSE: assert property (
      o_wake |-> $past(i_sleeping) && $past(wake_req))
      else $error("Wake without enabled clockless source");

   AST_SKIP_NO_ENTRY: assert property (
      (cur_ff.mode == icu_pkg::ICU_WAKE_SKIP) |=> !o_entry)
      else $error("Vector taken before instruction after sleep");

   AST_EXT_FALL: assert property (
      (cur_ff.ext_armed && !edge_rise && cur_ff.ext_prev && !i_ext_pin) |=> cur_ff.flg0[icu_pkg::EN0_EXTPIN_BIT])
      else $error("Falling edge did not set pin flag");

   AST_EXT_QUIET: assert property (
      (!cur_ff.flg0[icu_pkg::EN0_EXTPIN_BIT] && !wr_commit && (i_ext_pin == cur_ff.ext_prev)) |=>
         !cur_ff.flg0[icu_pkg::EN0_EXTPIN_BIT])
      else $error("Pin flag set without an edge");

   AST_PENDING_GATE: assert property (
      (!group_en && (term0 == 8'h00)) |=> !o_irq_pending)
      else $error("Group-gated source requested with group enable clear");

   AST_PENDING_EN0: assert property (
      (term0 != 8'h00) |=> o_irq_pending)
      else $error("Register 0 source did not request");

   AST_NO_TERM_NO_IRQ: assert property (
      ((term0 | term1 | term2) == 8'h00) |=> !o_irq_pending)
      else $error("Request without an enabled flag");

   AST_TIMER0_FLAG: assert property (
      i_evt.timer0_overflow |=> cur_ff.flg0[icu_pkg::EN0_TIMER0_BIT])
      else $error("Timer flag not set by event");

   AST_ZCROSS_FLAG: assert property (
      i_evt.zero_cross |=> cur_ff.flg2[icu_pkg::EN2_ZCROSS_BIT])
      else $error("Zero cross flag not set by event");

   AST_RESTORE_CAUSE: assert property (
      o_restore |-> $past(i_return_from_irq_instr))
      else $error("Restore without return instruction");

   COV_ENTRY:  cover property (o_entry ##[1:50] o_restore);
   COV_WAKE:   cover property (o_wake ##[1:20] o_entry);
   COV_EXTPIN: cover property (ext_edge && !edge_rise);
   COV_READ:   cover property (i_psel && i_penable && o_pready && !i_pwrite && !o_pslverr);
   COV_GROUP:  cover property (o_entry && !group_en);

endmodule

//--- icu_core_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Core sequencer stand-in facing the interrupt unit
module icu_core_model #(
   parameter logic [63:0] CTX0 = 64'h8a7b6c5d4e3f2a19
) (
   // Clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_b,
   // Bench requests
   input  wire logic              i_ret_req,
   input  wire logic              i_sleep_req,
   // From interrupt unit
   input  wire logic              i_restore,
   input  wire icu_pkg::icu_ctx_t i_restore_ctx,
   // To interrupt unit
   output logic                   o_q1,
   output logic                   o_sleeping,
   output logic                   o_ret,
   output icu_pkg::icu_ctx_t      o_ctx
);
   // Timeout and power-down stay with the core across a return
   localparam logic [63:0] KEEP = 64'h1800;
   logic [1:0] q_ff;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         q_ff <= 2'h0;
         o_q1 <= 1'b0;
         o_sleeping <= 1'b0;
         o_ret <= 1'b0;
         o_ctx <= CTX0;
      end else begin
         q_ff <= q_ff + 2'h1;
         o_q1 <= (q_ff == 2'h3);
         o_sleeping <= i_sleep_req;
         o_ret <= i_ret_req;
         if (i_restore) begin
            o_ctx <= (i_restore_ctx & ~KEEP) | (o_ctx & KEEP);
         end
      end
   end
endmodule

//--- tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
// ==========================================================================
// Self-checking bench
module tb;
   localparam logic [63:0] CTX0 = 64'h8a7b6c5d4e3f2a19;
   logic              clk, rst_b, psel, penable, pwrite, pin, ret_req, sleep_req;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              pready, pslverr, err, entry, restore, wake, pend, q1, slp, ret;
   logic [14:0]       vec;
   icu_pkg::icu_evt_t evt;
   icu_pkg::icu_ctx_t ctx, rctx;
   logic [7:0]        mask [3];
   int                mismatches, check_count, n_entry, n_restore, n_wake, n_q1;
   int                seed, k, q0, s;
   int                m_flg [3];

   icu_top dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_prdata(prdata), .i_evt(evt), .i_ext_pin(pin), .i_q1(q1),
      .i_sleeping(slp), .i_return_from_irq_instr(ret), .i_ctx(ctx), .o_entry(entry),
      .o_vec_addr(vec), .o_restore(restore), .o_restore_ctx(rctx), .o_wake(wake),
      .o_irq_pending(pend));
   icu_core_model #(.CTX0(CTX0)) core (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ret_req(ret_req),
      .i_sleep_req(sleep_req), .i_restore(restore), .i_restore_ctx(rctx), .o_q1(q1),
      .o_sleeping(slp), .o_ret(ret), .o_ctx(ctx));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pulse counters read pre-edge values, so no race with the design
   always @(posedge clk) begin
      n_entry <= n_entry + int'(entry === 1'b1);
      n_restore <= n_restore + int'(restore === 1'b1);
      n_wake <= n_wake + int'(wake === 1'b1);
      n_q1 <= n_q1 + int'(q1 === 1'b1 && slp === 1'b0);
   end

   task close_out;
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      evt <= v;
      @(posedge clk);
      evt <= '0;
      m_flg[0] |= {v[7], v[6], 4'h0};
      m_flg[1] |= {v[5], v[4], 5'h0, v[3]};
      m_flg[2] |= {v[2], 4'h0, v[1], v[0]};
   endtask
   task automatic wait_cnt(ref int c, input int v);
      int n;
      n = 0;
      while (c <= v && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) mismatches++;
   endtask
   task automatic ret_pulse;
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask

   initial begin
      #60000;
      mismatches++;
      close_out;
   end
   initial begin
      seed = 51;
      {psel, penable, pwrite, pin, ret_req, sleep_req, rst_b} = '0;
      paddr = '0;
      pwdata = '0;
      evt = '0;
      m_flg = '{0, 0, 0};
      mask = '{icu_pkg::EN0_MASK, icu_pkg::EN1_MASK, icu_pkg::EN2_MASK};
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      // ======================================================================
      // Reset values, masks, unmapped access
      rdc(icu_pkg::OFS_CTRL, {24'h0, icu_pkg::CTRL_RST});
      for (k = 0; k < 3; k++) rdc(8'(icu_pkg::OFS_EN0 + 4 * k), 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      wr(icu_pkg::OFS_CTRL, 32'hffffffff);
      rdc(icu_pkg::OFS_CTRL, 32'hc1);
      for (k = 0; k < 3; k++) begin
         wr(8'(icu_pkg::OFS_EN0 + 4 * k), 32'hff);
         rdc(8'(icu_pkg::OFS_EN0 + 4 * k), {24'h0, mask[k]});
         wr(8'(icu_pkg::OFS_EN0 + 4 * k), 32'h0);
      end
      wr(icu_pkg::OFS_CTRL, 32'h01);
      // ======================================================================
      // Random events set flags with every enable off
      repeat (6) begin
         pulse(8'($random(seed)));
         for (k = 0; k < 3; k++) rdc(8'(icu_pkg::OFS_FLG0 + 4 * k), m_flg[k]);
      end
      for (k = 0; k < 3; k++) wr(8'(icu_pkg::OFS_FLG0 + 4 * k), 32'h0);
      m_flg = '{0, 0, 0};
      // ======================================================================
      // Group gating, blocked vector, entry and return
      wr(icu_pkg::OFS_EN1, 32'h01);
      pulse(8'h08);
      repeat (3) @(posedge clk);
      `CHK(pend, 1'b0)
      wr(icu_pkg::OFS_CTRL, 32'h41);
      repeat (3) @(posedge clk);
      `CHK(pend, 1'b1)
      q0 = n_entry;
      repeat (12) @(posedge clk);
      `CHK(n_entry, q0)
      wr(icu_pkg::OFS_CTRL, 32'hc1);
      wait_cnt(n_entry, q0);
      `CHK(vec, icu_pkg::VECTOR_ADDR)
      rdc(icu_pkg::OFS_CTRL, 32'h41);
      rdc(8'(icu_pkg::OFS_SHD_BASE + 4), {24'h0, CTX0[15:8] & icu_pkg::STATUS_SAVE_MASK});
      q0 = n_entry;
      ret_pulse;
      wait_cnt(n_entry, q0);
      `CHK(n_entry > q0, 1'b1)
      wr(icu_pkg::OFS_FLG1, 32'h0);
      wr(icu_pkg::OFS_SHD_BASE, 32'h5a);
      q0 = n_restore;
      ret_pulse;
      wait_cnt(n_restore, q0);
      `CHK({rctx[0], rctx[2]}, {8'h5a, CTX0[23:16]})
      rdc(icu_pkg::OFS_CTRL, 32'hc1);
      q0 = n_entry;
      repeat (12) @(posedge clk);
      `CHK(n_entry, q0)
      // ======================================================================
      // External pin edge select, both polarities
      for (s = 1; s >= 0; s--) begin
         wr(icu_pkg::OFS_CTRL, 32'(s));
         wr(icu_pkg::OFS_FLG0, 32'h0);
         repeat (2) begin
            @(posedge clk);
            pin <= ~pin;
            repeat (3) @(posedge clk);
            rdc(icu_pkg::OFS_FLG0, 32'(pin == s[0]));
            wr(icu_pkg::OFS_FLG0, 32'h0);
         end
      end
      // ======================================================================
      // Wake on a register-0 source with the group enable off
      wr(icu_pkg::OFS_EN0, 32'h20);
      wr(icu_pkg::OFS_CTRL, 32'h81);
      sleep_req <= 1'b1;
      repeat (3) @(posedge clk);
      q0 = n_wake;
      pulse(8'h80);
      wait_cnt(n_wake, q0);
      `CHK(n_wake, q0 + 1)
      sleep_req <= 1'b0;
      k = n_q1;
      q0 = n_entry;
      wait_cnt(n_entry, q0);
      `CHK(n_q1 - k >= 2, 1'b1)
      // ======================================================================
      // Reset in mid-run drops the enables and flags left set above
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdc(icu_pkg::OFS_CTRL, {24'h0, icu_pkg::CTRL_RST});
      rdc(icu_pkg::OFS_EN0, 32'h0);
      rdc(icu_pkg::OFS_FLG0, 32'h0);
      close_out;
   end
endmodule
